// ---- core/dpi_pkg.sv ----
// Constants shared by the digital I/O process image block and its helpers.
// Assumes one 200 MHz clock and a plain word-wide register port.

package dpi_pkg;

  // ==========================================
  // Register port
  localparam int unsigned DPI_AW = 8;
  localparam int unsigned DPI_DW = 32;
  localparam logic [7:0] DPI_OFS_THERM_IN = 8'h00;
  localparam logic [7:0] DPI_OFS_THERM_OUT = 8'h04;
  localparam logic [7:0] DPI_OFS_WIDE_IN = 8'h08;
  localparam logic [7:0] DPI_OFS_DO1 = 8'h0c;
  localparam logic [7:0] DPI_OFS_DO2 = 8'h10;
  localparam logic [7:0] DPI_OFS_DDO = 8'h14;
  localparam logic [7:0] DPI_OFS_ANA = 8'h18;
  localparam logic [7:0] DPI_OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] DPI_OFS_IRQ_MASK = 8'h20;

  // ==========================================
  // Channel counts and image sizes
  localparam int unsigned DPI_BYTE = 8;
  localparam int unsigned DPI_THERM_CH = 8;
  localparam int unsigned DPI_WIDE_CH = 16;
  localparam int unsigned DPI_DO2_CH = 2;
  localparam int unsigned DPI_DDO_CH = 4;
  localparam int unsigned DPI_ANA_BYTES = 2;
  localparam int unsigned DPI_DIG_BYTES = 1;

  // ==========================================
  // Field positions
  localparam int unsigned DPI_THERM_FAULT_LSB = 8;
  localparam int unsigned DPI_THERM_OFF_LSB = 8;
  localparam int unsigned DPI_DO1_CTRL_BIT = 0;
  localparam int unsigned DPI_DO1_MAN_BIT = 0;
  localparam int unsigned DPI_DO1_RB_BIT = 8;
  localparam int unsigned DPI_DDO_FAULT_LSB = 8;

  // ==========================================
  // Interrupt sources
  localparam int unsigned DPI_IRQ_W = 3;
  localparam int unsigned DPI_IRQ_THERM_FAULT = 0;
  localparam int unsigned DPI_IRQ_DDO_FAULT = 1;
  localparam int unsigned DPI_IRQ_MANUAL = 2;

  // ==========================================
  // Reset values
  localparam logic [7:0] DPI_THERM_OFF_RST = 8'h00;
  localparam logic [31:0] DPI_WORD_ZERO = 32'h0000_0000;

endpackage

// ---- core/dpi_therm_gate.sv ----
// Thermistor input channel gate: state and fault capture with per-channel switch-off.
// Assumes raw channel levels are synchronous to clk_i.

`timescale 1ns/10ps

module dpi_therm_gate #(
  parameter int unsigned N = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Channel side
  input wire logic [N-1:0] state_i,
  input wire logic [N-1:0] fault_i,
  input wire logic [N-1:0] off_i,
  // Image side
  output logic [N-1:0] state_o,
  output logic [N-1:0] fault_o,
  output logic new_fault_o
);

  typedef struct packed {
    logic [N-1:0] state;
    logic [N-1:0] fault;
    logic rise;
  } dpi_gate_st_t;

  dpi_gate_st_t st;
  dpi_gate_st_t next_st;

  always_comb
  begin
    next_st = st;
    // Switched-off channels report nothing, so a dead sensor cannot raise faults
    next_st.state = state_i & ~off_i;
    next_st.fault = fault_i & ~off_i;
    next_st.rise = |(next_st.fault & ~st.fault);
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign state_o = st.state;
  assign fault_o = st.fault;
  assign new_fault_o = st.rise;

endmodule

// ---- core/dpi_irq_bank.sv ----
// Sticky event flags with mask and one level interrupt.
// Assumes events are one-cycle pulses; a one written to a flag clears it.

`timescale 1ns/10ps

module dpi_irq_bank #(
  parameter int unsigned W = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Events
  input wire logic [W-1:0] event_i,
  // Software access
  input wire logic clr_we_i,
  input wire logic mask_we_i,
  input wire logic [W-1:0] wdata_i,
  output logic [W-1:0] status_o,
  output logic [W-1:0] mask_o,
  output logic irq_o
);

  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
  } dpi_irq_st_t;

  dpi_irq_st_t st;
  dpi_irq_st_t next_st;

  always_comb
  begin
    next_st = st;
    if (clr_we_i)
    begin
      next_st.status = st.status & ~wdata_i;
    end
    // Set after clear, so an event in the clearing cycle is kept
    next_st.status = next_st.status | event_i;
    if (mask_we_i)
    begin
      next_st.mask = wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign status_o = st.status;
  assign mask_o = st.mask;
  assign irq_o = |(st.status & st.mask);

endmodule

// ---- core/dpi_image.sv ----
// Digital I/O process image: thermistor input, 16-channel input and output modules.
// Assumes all channel inputs are synchronous to clk_i and a single-master register port.

`timescale 1ns/10ps

// Notes on behaviour
// - The thermistor module uses one logical channel of two input bytes and two output bytes.
// - Thermistor input byte D0 carries the state of channels 1 to 8, channel n at bit n-1.
// - Thermistor input byte D1 carries one wire-break or short-circuit flag per channel, bit n-1.
// - Thermistor output byte D1 bit n-1 at 0 keeps channel n active and at 1 switches it off.
// - The 16-channel input module maps channels 1-8 to bits 0-7 and 9-16 to bits 8-15.
// - Each digital output channel is driven by exactly one dedicated output image bit.
// - Diagnostic outputs report one fault bit per channel next to the data bits to examine.
// - With analog outputs present the digital output data follows them, packed into whole bytes.
// - The single-channel output takes control from bit 0; input bit 0 shows manual mode, bit 1 unused.
// - The two-channel output drives channel 1 from bit 0 and channel 2 from bit 1.
module dpi_image
  import dpi_pkg::*;
#(
  parameter int unsigned THERM_CH = dpi_pkg::DPI_THERM_CH,
  parameter int unsigned DDO_CH = dpi_pkg::DPI_DDO_CH,
  parameter int unsigned ANA_BYTES = dpi_pkg::DPI_ANA_BYTES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [dpi_pkg::DPI_AW-1:0] addr_i,
  input wire logic [dpi_pkg::DPI_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [dpi_pkg::DPI_DW-1:0] rdata_o,
  // Thermistor input module
  input wire logic [THERM_CH-1:0] input_state_bit_i,
  input wire logic [THERM_CH-1:0] therm_fault_i,
  output logic [THERM_CH-1:0] channel_switch_off_o,
  // Sixteen-channel input module
  input wire logic [dpi_pkg::DPI_WIDE_CH-1:0] wide_in_i,
  // Single-channel output module
  input wire logic do1_manual_i,
  output logic do1_o,
  // Two-channel output module
  output logic [dpi_pkg::DPI_DO2_CH-1:0] do2_o,
  // Diagnostic output module
  input wire logic [DDO_CH-1:0] ddo_fault_i,
  output logic [DDO_CH-1:0] ddo_o,
  // Packed output image
  output logic [(ANA_BYTES+dpi_pkg::DPI_DIG_BYTES)*dpi_pkg::DPI_BYTE-1:0] out_image_o,
  // Interrupt
  output logic irq_o
);

  import dpi_pkg::*;

  localparam int unsigned ANA_W = ANA_BYTES * DPI_BYTE;
  localparam int unsigned DIG_W = DPI_DIG_BYTES * DPI_BYTE;
  localparam int unsigned DIG_USED = 1 + DPI_DO2_CH + DDO_CH;

  // ==========================================
  // State
  typedef struct packed {
    logic [THERM_CH-1:0] off;
    logic do1;
    logic [DPI_DO2_CH-1:0] do2;
    logic [DDO_CH-1:0] ddo;
    logic [ANA_W-1:0] ana;
    logic [DPI_WIDE_CH-1:0] wide;
    logic manual;
    logic manual_evt;
    logic [DDO_CH-1:0] ddo_fault;
    logic ddo_evt;
    logic [DPI_DW-1:0] rdata;
    logic [ANA_W+DIG_W-1:0] img;
  } dpi_top_st_t;

  dpi_top_st_t st;
  dpi_top_st_t next_st;

  logic [THERM_CH-1:0] therm_state;
  logic [THERM_CH-1:0] therm_fault;
  logic therm_new_fault;
  logic [DPI_IRQ_W-1:0] irq_evt;
  logic [DPI_IRQ_W-1:0] irq_status;
  logic [DPI_IRQ_W-1:0] irq_mask;
  logic wr_stat;
  logic wr_mask;

  // ==========================================
  // Helpers
  // Places a narrow field at a bit position of a read word, rest zero
  function automatic logic [DPI_DW-1:0] place(input logic [DPI_DW-1:0] v, input int unsigned lsb);
    place = v << lsb;
  endfunction

  function automatic logic hit(input logic [DPI_AW-1:0] a, input logic [DPI_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================
  // Thermistor channels
  dpi_therm_gate #(
    .N(THERM_CH)
  ) u_therm (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .state_i(input_state_bit_i),
    .fault_i(therm_fault_i),
    .off_i(st.off),
    .state_o(therm_state),
    .fault_o(therm_fault),
    .new_fault_o(therm_new_fault)
  );

  // ==========================================
  // Interrupt flags
  always_comb
  begin
    irq_evt = '0;
    irq_evt[DPI_IRQ_THERM_FAULT] = therm_new_fault;
    irq_evt[DPI_IRQ_DDO_FAULT] = st.ddo_evt;
    irq_evt[DPI_IRQ_MANUAL] = st.manual_evt;
  end

  assign wr_stat = wr_i & hit(addr_i, DPI_OFS_IRQ_STAT);
  assign wr_mask = wr_i & hit(addr_i, DPI_OFS_IRQ_MASK);

  dpi_irq_bank #(
    .W(DPI_IRQ_W)
  ) u_irq (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .event_i(irq_evt),
    .clr_we_i(wr_stat),
    .mask_we_i(wr_mask),
    .wdata_i(wdata_i[DPI_IRQ_W-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // ==========================================
  // Next state
  always_comb
  begin
    next_st = st;

    // Input sampling and change events
    next_st.wide = wide_in_i;
    next_st.manual = do1_manual_i;
    next_st.manual_evt = do1_manual_i ^ st.manual;
    next_st.ddo_fault = ddo_fault_i;
    next_st.ddo_evt = |(ddo_fault_i & ~st.ddo_fault);

    // Writes; only the bits that steer a channel are kept, the rest dropped
    if (wr_i)
    begin
      if (hit(addr_i, DPI_OFS_THERM_OUT))
      begin
        // Reserved low byte is not stored at all
        next_st.off = wdata_i[DPI_THERM_OFF_LSB +: THERM_CH];
      end
      if (hit(addr_i, DPI_OFS_DO1))
      begin
        next_st.do1 = wdata_i[DPI_DO1_CTRL_BIT];
      end
      if (hit(addr_i, DPI_OFS_DO2))
      begin
        next_st.do2 = wdata_i[DPI_DO2_CH-1:0];
      end
      if (hit(addr_i, DPI_OFS_DDO))
      begin
        next_st.ddo = wdata_i[DDO_CH-1:0];
      end
      if (hit(addr_i, DPI_OFS_ANA))
      begin
        next_st.ana = wdata_i[ANA_W-1:0];
      end
    end

    // Read data stands for exactly one cycle after the strobe
    next_st.rdata = DPI_WORD_ZERO;
    if (rd_i)
    begin
      unique case (addr_i)
        DPI_OFS_THERM_IN:
        begin
          next_st.rdata = place(DPI_DW'(therm_state), 0)
            | place(DPI_DW'(therm_fault), DPI_THERM_FAULT_LSB);
        end
        DPI_OFS_THERM_OUT:
        begin
          next_st.rdata = place(DPI_DW'(st.off), DPI_THERM_OFF_LSB);
        end
        DPI_OFS_WIDE_IN:
        begin
          next_st.rdata = place(DPI_DW'(st.wide), 0);
        end
        DPI_OFS_DO1:
        begin
          // Bit 1 of the input byte stays zero
          next_st.rdata = place(DPI_DW'(st.manual), DPI_DO1_MAN_BIT)
            | place(DPI_DW'(st.do1), DPI_DO1_RB_BIT);
        end
        DPI_OFS_DO2:
        begin
          next_st.rdata = place(DPI_DW'(st.do2), 0);
        end
        DPI_OFS_DDO:
        begin
          // Data beside the fault bits, so software can judge both together
          next_st.rdata = place(DPI_DW'(st.ddo), 0)
            | place(DPI_DW'(st.ddo_fault), DPI_DDO_FAULT_LSB);
        end
        DPI_OFS_ANA:
        begin
          next_st.rdata = place(DPI_DW'(st.ana), 0);
        end
        DPI_OFS_IRQ_STAT:
        begin
          next_st.rdata = place(DPI_DW'(irq_status), 0);
        end
        DPI_OFS_IRQ_MASK:
        begin
          next_st.rdata = place(DPI_DW'(irq_mask), 0);
        end
        default:
        begin
          next_st.rdata = DPI_WORD_ZERO;
        end
      endcase
    end

    // Digital bits follow the analog bytes, padded to a whole byte
    // Built from the next values so the image moves in the same cycle as the channel outputs
    next_st.img = {DIG_W'({next_st.ddo, next_st.do2, next_st.do1}), next_st.ana};
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st <= '0;
      st.off <= THERM_CH'(DPI_THERM_OFF_RST);
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================
  // Outputs
  // One image bit per output channel, no sharing
  assign channel_switch_off_o = st.off;
  assign do1_o = st.do1;
  assign do2_o = st.do2;
  assign ddo_o = st.ddo;
  assign out_image_o = st.img;
  assign rdata_o = st.rdata;

endmodule

// ---- verification/dpi_image_props.sv ----
// Port checker for the process image block.
// Assumes one clock domain and the register map of dpi_pkg.
`timescale 1ns/10ps
module dpi_image_chk
  import dpi_pkg::*;
#(
  parameter int unsigned THERM_CH = 8,
  parameter int unsigned DDO_CH = 4,
  parameter int unsigned ANA_BYTES = 2
) (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [dpi_pkg::DPI_AW-1:0] addr_i,
  input wire logic [dpi_pkg::DPI_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [dpi_pkg::DPI_DW-1:0] rdata_o,
  // Channels
  input wire logic [THERM_CH-1:0] input_state_bit_i,
  input wire logic [THERM_CH-1:0] therm_fault_i,
  input wire logic [THERM_CH-1:0] channel_switch_off_o,
  input wire logic [dpi_pkg::DPI_WIDE_CH-1:0] wide_in_i,
  input wire logic do1_o,
  input wire logic [dpi_pkg::DPI_DO2_CH-1:0] do2_o,
  input wire logic [DDO_CH-1:0] ddo_fault_i,
  input wire logic [DDO_CH-1:0] ddo_o,
  input wire logic [(ANA_BYTES+dpi_pkg::DPI_DIG_BYTES)*dpi_pkg::DPI_BYTE-1:0] out_image_o
);
  // ==========
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_OFF_WR: assert property (wr_i && addr_i == 8'h04 |=> channel_switch_off_o == $past(wdata_i[15:8]))
    else $error("switch-off bits not taken from byte one");
  AST_OFF_HOLD: assert property (!(wr_i && addr_i == 8'h04) |=> $stable(channel_switch_off_o))
    else $error("switch-off bits moved without a write");
  AST_OFF_RD: assert property (rd_i && addr_i == 8'h04 |=> rdata_o[7:0] == 8'h00)
    else $error("reserved output byte reads nonzero");
  AST_THERM: assert property (rd_i && addr_i == 8'h00 && $stable(input_state_bit_i) && $stable(therm_fault_i)
    && $stable(channel_switch_off_o) |=> rdata_o[15:0] == {$past(therm_fault_i) & ~$past(channel_switch_off_o),
    $past(input_state_bit_i) & ~$past(channel_switch_off_o)})
    else $error("thermistor input bytes wrong");
  AST_WIDE: assert property (rd_i && addr_i == 8'h08 && $stable(wide_in_i) |=> rdata_o == {16'h0000, $past(wide_in_i)})
    else $error("wide input bytes wrong");
  AST_DO1: assert property (wr_i && addr_i == 8'h0c |=> do1_o == $past(wdata_i[0]))
    else $error("single output not from bit zero");
  AST_DO1_HOLD: assert property (!(wr_i && addr_i == 8'h0c) |=> $stable(do1_o))
    else $error("single output moved without a write");
  AST_DO1_RD: assert property (rd_i && addr_i == 8'h0c |=> rdata_o[1] == 1'b0)
    else $error("unused status bit reads one");
  AST_DO2: assert property (wr_i && addr_i == 8'h10 |=> do2_o == $past(wdata_i[1:0]))
    else $error("two-channel outputs wrong");
  AST_DDO: assert property (wr_i && addr_i == 8'h14 |=> ddo_o == $past(wdata_i[3:0]))
    else $error("diagnostic outputs wrong");
  AST_DDO_RD: assert property (rd_i && addr_i == 8'h14 && $stable(ddo_fault_i)
    |=> rdata_o[11:8] == $past(ddo_fault_i) && rdata_o[3:0] == $past(ddo_o))
    else $error("diagnostic fault bits wrong");
  AST_IMG: assert property (out_image_o[23:16] == {1'b0, ddo_o, do2_o, do1_o})
    else $error("digital image byte wrong");
endmodule
bind dpi_image dpi_image_chk #(.THERM_CH(THERM_CH), .DDO_CH(DDO_CH), .ANA_BYTES(ANA_BYTES)) chk_u (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .input_state_bit_i(input_state_bit_i), .therm_fault_i(therm_fault_i),
  .channel_switch_off_o(channel_switch_off_o), .wide_in_i(wide_in_i), .do1_o(do1_o), .do2_o(do2_o),
  .ddo_fault_i(ddo_fault_i), .ddo_o(ddo_o), .out_image_o(out_image_o));

// ---- verification/dpi_ctl_model.sv ----
// Controller model: writes and reads the process image over the register port.
// Assumes a slave with no wait states and read data one cycle later.
`timescale 1ns/10ps
module dpi_ctl_model (
  // Bus
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // ==========
  // Bus cycles
  initial {addr_o, wdata_o, wr_o, rd_o} = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
  // Reserved byte zero always goes out as zero
  task automatic set_off(input logic [7:0] o);
    wr(8'h04, {16'h0000, o, 8'h00});
  endtask
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the process image block.
// Assumes dpi_ctl_model as bus master and the bound port checker.
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
  import dpi_pkg::*;
  // ==========
  // Signals and model state
  logic clk_i = 0, sys_rst_i = 1, man = 0, wr_i, rd_i, do1_o, irq_o;
  logic [7:0] addr_i, st = 0, ft = 0, off = 0, cso;
  logic [15:0] wide = 0, ana = 0;
  logic [31:0] wdata_i, rdata_o, r = 32'h0001762c, d;
  logic [3:0] ddf = 0, dd = 0, ddo_o;
  logic [1:0] d2 = 0, do2_o;
  logic d1 = 0;
  logic [23:0] img;
  int n_mismatch = 0, tests_run = 0;
  logic [7:0] al[$] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h24};
  always #2.5 clk_i = ~clk_i;
  dpi_image dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .input_state_bit_i(st), .therm_fault_i(ft), .channel_switch_off_o(cso),
    .wide_in_i(wide), .do1_manual_i(man), .do1_o(do1_o), .do2_o(do2_o), .ddo_fault_i(ddf), .ddo_o(ddo_o),
    .out_image_o(img), .irq_o(irq_o));
  dpi_ctl_model ctl_u (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
    .rd_o(rd_i));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] ex(input logic [7:0] a);
    case (a)
      8'h00: ex = {16'h0, ft & ~off, st & ~off};
      8'h04: ex = {16'h0, off, 8'h00};
      8'h08: ex = {16'h0, wide};
      8'h0c: ex = {23'h0, d1, 7'h00, man};
      8'h10: ex = {30'h0, d2};
      8'h14: ex = {20'h0, ddf, 4'h0, dd};
      8'h18: ex = {16'h0, ana};
      default: ex = 32'h0;
    endcase
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic irq_step(input logic [7:0] a, input logic [31:0] v, input logic e);
    ctl_u.wr(a, v);
    repeat (4) @(posedge clk_i);
    #1 `CHK("irq", e, irq_o)
  endtask
  // ==========
  // Sequence
  initial
  begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1 `CHK("reset", 40'h0, {img, cso, do1_o, do2_o, ddo_o, irq_o})
    for (int i = 0; i < 24; i++)
    begin
      r = nx(r);
      st <= r[7:0];
      ft <= r[15:8];
      wide <= r[31:16];
      man <= r[3];
      ddf <= r[7:4];
      r = nx(r);
      off = r[31:24];
      d1 = r[0];
      d2 = r[1:0];
      dd = r[3:0];
      ana = r[15:0];
      ctl_u.set_off(off);
      foreach (al[k]) ctl_u.wr(al[k], (al[k] == 8'h04) ? {16'h0, off, 8'h00} : r);
      ctl_u.wr(8'h04, {r[31:16], off, 8'h00});
      foreach (al[k])
      begin
        ctl_u.rd(al[k], d);
        `CHK("read", ex(al[k]), d)
      end
      `CHK("outs", {off, d1, d2, dd}, {cso, do1_o, do2_o, ddo_o})
      `CHK("image", {1'b0, dd, d2, d1, ana}, img)
    end
    $display("test random image done");
    {st, ft, ddf, man} <= '0;
    ctl_u.set_off(8'h00);
    irq_step(8'h1c, 32'h7, 1'b0);
    irq_step(8'h20, 32'h1, 1'b0);
    ft <= 8'h80;
    irq_step(8'h1c, 32'h0, 1'b1);
    irq_step(8'h1c, 32'h1, 1'b0);
    ddf <= 4'h1;
    irq_step(8'h18, 32'h0, 1'b0);
    ctl_u.rd(8'h1c, d);
    `CHK("status", 32'h2, d)
    irq_step(8'h20, 32'h2, 1'b1);
    ctl_u.rd(8'h20, d);
    `CHK("mask", 32'h2, d)
    man <= 1'b1;
    irq_step(8'h1c, 32'h2, 1'b0);
    ctl_u.rd(8'h1c, d);
    `CHK("manual", 32'h4, d)
    $display("test interrupt done");
    summarize();
  end
endmodule
